// File: ebc_pkg.sv
// Purpose: Shared constants for the external bus cycle controller.
// Assumes: 10 MHz system clock; bus reference clock is CLK divided by two.
// Notes:   Monitor periods are in bus reference clock cycles.
package ebc_pkg;
  localparam int unsigned CLK_HZ            = 10_000_000;
  localparam int unsigned MIN_CYCLES_ACK    = 3;
  localparam int unsigned FAST_CYCLES       = 2;
  localparam int unsigned MON_MAX_CYCLES    = 64;
  localparam logic [3:0]  ACK_OPT_FAST      = 4'he;
  localparam logic [3:0]  ACK_OPT_EXTERNAL  = 4'hf;
  localparam logic [2:0]  FC_CONTROL_SPACE  = 3'h7;
  localparam logic [3:0]  CTYPE_BKPT_ACK    = 4'h0;
  localparam logic [3:0]  CTYPE_LP_STOP     = 4'h3;
  localparam logic [3:0]  CTYPE_INT_ACK     = 4'hf;
  localparam logic [1:0]  SIZE_BYTE         = 2'h1;
  localparam logic [1:0]  SIZE_WORD         = 2'h2;
  localparam logic [1:0]  SIZE_LONG         = 2'h0;
  localparam logic [1:0]  ACK_WAIT          = 2'h3;
  localparam logic [1:0]  ACK_PORT8         = 2'h2;
  localparam logic [1:0]  ACK_PORT16        = 2'h1;
  localparam logic [1:0]  ACK_RSVD          = 2'h0;
  localparam logic [1:0]  RESULT_OK         = 2'h0;
  localparam logic [1:0]  RESULT_BUS_ERR    = 2'h1;
  localparam logic [1:0]  RESULT_TIMEOUT    = 2'h2;
  localparam logic        CS_TIMING_SELECT_ADDR         = 1'b0;
endpackage : ebc_pkg

// File: ebc_bus_monitor.sv
// Purpose: Response-time watchdog for one external bus cycle.
// Assumes: tick is a one-cycle enable per bus reference clock cycle.
// Notes:   Cannot be disabled; the period field picks 8, 16, 32 or 64 cycles.
module ebc_bus_monitor
  import ebc_pkg::*;
#(
  parameter int unsigned MAX_CYCLES = MON_MAX_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       restart,
  input  wire logic       stop,
  input  wire logic       tick,
  input  wire logic [1:0] period_sel,
  output logic            expired
);
  initial begin
    if (MAX_CYCLES < 8 || MAX_CYCLES > 255) $error("MAX_CYCLES out of range");
  end

  logic [7:0] cnt_ff;
  logic       run_ff;
  logic [7:0] limit;

  // Longest selection equals MAX_CYCLES; each step below halves it
  assign limit = 8'(MAX_CYCLES >> (2'd3 - period_sel));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff  <= 8'h00;
      run_ff  <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (restart) begin
        cnt_ff <= 8'h00;
        run_ff <= 1'b1;
      end else if (stop) begin
        run_ff <= 1'b0;
      end else if (run_ff && tick) begin
        if (cnt_ff + 8'h01 >= limit) begin
          expired <= 1'b1;
          run_ff  <= 1'b0;
        end
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end
endmodule : ebc_bus_monitor

// File: ebc_bus_master.sv
// Purpose: External bus master sequencing regular, fast and control-space cycles.
// Assumes: Bus inputs are asynchronous and pass two flip-flops before use.
// Notes:   Bus reference clock is CLK/2; falling phase on ph_ff=1 toggling to 0.
module ebc_bus_master
  import ebc_pkg::*;
#(
  parameter int unsigned ADDR_W = 24
) (
  input  wire logic              CLK,
  input  wire logic              RESET_N,
  input  wire logic              REQ_VALID,
  input  wire logic              REQ_WRITE,
  input  wire logic [1:0]        REQ_SIZE,
  input  wire logic [ADDR_W-1:0] REQ_ADDR,
  input  wire logic [2:0]        REQ_SPACE,
  input  wire logic [3:0]        REQ_CTYPE,
  input  wire logic [15:0]       REQ_WDATA,
  input  wire logic [3:0]        CS_ACK_OPT,
  input  wire logic              CS_TIMING_SELECT,
  input  wire logic [1:0]        MONITOR_PERIOD_SEL,
  input  wire logic [1:0]        DATA_SIZE_ACK_N,
  input  wire logic              BUS_ERROR_IN_N,
  input  wire logic              HALT_N,
  input  wire logic [15:0]       DATA_IN,
  output logic                   REQ_READY,
  output logic                   DONE,
  output logic [1:0]             DONE_RESULT,
  output logic                   DONE_PORT8,
  output logic [15:0]            RDATA,
  output logic                   BUS_REFERENCE_CLOCK,
  output logic [ADDR_W-1:0]      ADDR_OUT,
  output logic [1:0]             BYTE_COUNT_CODE,
  output logic [2:0]             FUNCTION_CODE,
  output logic                   ADDRESS_STROBE_N,
  output logic                   DATA_STROBE_N,
  output logic                   READ_WRITE_N,
  output logic [15:0]            DATA_OUT,
  output logic                   DATA_OE
);
  initial begin
    if (ADDR_W < 20) $error("ADDR_W must hold control-space type field");
  end

  typedef enum {ST_IDLE, ST_S0, ST_S1, ST_WAIT, ST_LATCH, ST_END} ebc_state_t;

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [1:0]  ack_m_ff, ack_ff;
  logic        bus_error_in_m_ff, bus_error_in_ff, halt_m_ff, halt_ff;
  logic [15:0] din_m_ff, din_ff;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_m_ff  <= ACK_WAIT;
      ack_ff    <= ACK_WAIT;
      bus_error_in_m_ff <= 1'b1;
      bus_error_in_ff   <= 1'b1;
      halt_m_ff <= 1'b1;
      halt_ff   <= 1'b1;
      din_m_ff  <= 16'h0000;
      din_ff    <= 16'h0000;
    end else begin
      ack_m_ff  <= DATA_SIZE_ACK_N;
      ack_ff    <= ack_m_ff;
      bus_error_in_m_ff <= BUS_ERROR_IN_N;
      bus_error_in_ff   <= bus_error_in_m_ff;
      halt_m_ff <= HALT_N;
      halt_ff   <= halt_m_ff;
      din_m_ff  <= DATA_IN;
      din_ff    <= din_m_ff;
    end
  end

  // ----------------------------------------------------------------
  // Bus reference clock divider
  // ----------------------------------------------------------------
  logic ph_ff;
  logic fall_en;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ph_ff               <= 1'b0;
      BUS_REFERENCE_CLOCK <= 1'b0;
    end else begin
      ph_ff               <= ~ph_ff;
      BUS_REFERENCE_CLOCK <= ~ph_ff;
    end
  end
  // State machine advances once per bus clock, on the falling-edge phase, except the timeout jump to ST_END, taken on the other phase
  assign fall_en = ph_ff;

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  ebc_state_t  state_ff;
  logic        fast_ff, write_ff, port8_ff;
  logic [1:0]  result_ff;
  logic        mon_expired;
  logic        mon_restart;
  logic        term_ack, term_err;

  // Both-low is reserved and treated as no acknowledge
  function automatic logic ack_valid(input logic [1:0] a);
    return (a == ACK_PORT8) || (a == ACK_PORT16);
  endfunction

  // Halt alone is ignored here; with bus error it is bus error
  assign term_err    = !bus_error_in_ff || mon_expired;
  assign term_ack    = fast_ff || ack_valid(ack_ff);
  assign mon_restart = (state_ff == ST_IDLE) && REQ_VALID && fall_en;

  ebc_bus_monitor #(
    .MAX_CYCLES (MON_MAX_CYCLES)
  ) u_monitor (
    .clk        (CLK),
    .reset_n    (RESET_N),
    .restart    (mon_restart),
    .stop       (state_ff == ST_LATCH || state_ff == ST_END),
    .tick       (fall_en),
    .period_sel (MONITOR_PERIOD_SEL),
    .expired    (mon_expired)
  );

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff  <= ST_IDLE;
      fast_ff   <= 1'b0;
      write_ff  <= 1'b0;
      port8_ff  <= 1'b0;
      result_ff <= RESULT_OK;
    end else if (mon_expired && state_ff != ST_IDLE && state_ff != ST_END) begin
      state_ff  <= ST_END;
      result_ff <= RESULT_TIMEOUT;
    end else if (fall_en) begin
      case (state_ff)
        ST_IDLE: if (REQ_VALID) begin
          state_ff  <= ST_S0;
          // A fast write without address strobe timing falls back to external acknowledge
          fast_ff   <= (CS_ACK_OPT == ACK_OPT_FAST)
                       && (!REQ_WRITE || CS_TIMING_SELECT == CS_TIMING_SELECT_ADDR);
          write_ff  <= REQ_WRITE;
          result_ff <= RESULT_OK;
        end
        ST_S0: state_ff <= fast_ff ? ST_LATCH : ST_S1;
        ST_S1: begin
          if (term_err) begin
            state_ff  <= ST_END;
            result_ff <= RESULT_BUS_ERR;
          end else if (term_ack) begin
            state_ff <= ST_LATCH;
            port8_ff <= (ack_ff == ACK_PORT8);
          end else begin
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (term_err) begin
            state_ff  <= ST_END;
            result_ff <= RESULT_BUS_ERR;
          end else if (term_ack) begin
            state_ff <= ST_LATCH;
            port8_ff <= (ack_ff == ACK_PORT8);
          end
        end
        ST_LATCH: begin
          state_ff <= ST_END;
          // Late bus error after acknowledge still aborts the cycle
          if (!bus_error_in_ff) result_ff <= RESULT_BUS_ERR;
        end
        ST_END:  state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pins and answers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ADDR_OUT         <= '0;
      BYTE_COUNT_CODE  <= SIZE_BYTE;
      FUNCTION_CODE    <= 3'h0;
      READ_WRITE_N     <= 1'b1;
      DATA_OUT         <= 16'h0000;
      DATA_OE          <= 1'b0;
    end else if (state_ff == ST_IDLE && REQ_VALID && fall_en) begin
      ADDR_OUT        <= REQ_ADDR;
      if (REQ_SPACE == FC_CONTROL_SPACE) begin
        ADDR_OUT[19:16] <= REQ_CTYPE;
      end
      BYTE_COUNT_CODE <= REQ_SIZE;
      FUNCTION_CODE   <= REQ_SPACE;
      READ_WRITE_N    <= ~REQ_WRITE;
      // Bytes ride on 15..8 so 8-bit ports see them
      DATA_OUT        <= (REQ_SIZE == SIZE_BYTE) ? {REQ_WDATA[7:0], REQ_WDATA[7:0]} : REQ_WDATA;
      DATA_OE         <= REQ_WRITE;
    end else if (state_ff == ST_END && fall_en) begin
      DATA_OE         <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ADDRESS_STROBE_N <= 1'b1;
      DATA_STROBE_N    <= 1'b1;
    end else begin
      // Strobes assert a half bus clock after address to leave setup
      ADDRESS_STROBE_N <= !(state_ff inside {ST_S0, ST_S1, ST_WAIT, ST_LATCH});
      DATA_STROBE_N    <= !((state_ff inside {ST_S0, ST_S1, ST_WAIT, ST_LATCH})
                            && !(fast_ff && write_ff));
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REQ_READY   <= 1'b0;
      DONE        <= 1'b0;
      DONE_RESULT <= RESULT_OK;
      DONE_PORT8  <= 1'b0;
      RDATA       <= 16'h0000;
    end else begin
      REQ_READY <= (state_ff == ST_IDLE) && !ph_ff;
      DONE      <= (state_ff == ST_END) && fall_en;
      if (state_ff == ST_LATCH && fall_en && !write_ff) begin
        // Narrow ports return their byte on 15..8
        RDATA <= (port8_ff && !fast_ff) ? {8'h00, din_ff[15:8]} : din_ff;
      end
      if (state_ff == ST_END && fall_en) begin
        DONE_RESULT <= result_ff;
        DONE_PORT8  <= port8_ff && !fast_ff;
      end
    end
  end
endmodule : ebc_bus_master

// File: ebc_bm_props.sv
// Purpose: Pin timing checks for the bus master
// Assumes: One clock domain, async active-low reset
// Notes:   Ages saturate; a small age means the line was low lately
module ebc_bm_props
  import ebc_pkg::*;
#(
  parameter int unsigned ADDR_W = 24
) (
  input wire logic              CLK,
  input wire logic              RESET_N,
  input wire logic [3:0]        CS_ACK_OPT,
  input wire logic [1:0]        DATA_SIZE_ACK_N,
  input wire logic              BUS_ERROR_IN_N,
  input wire logic              DONE,
  input wire logic [1:0]        DONE_RESULT,
  input wire logic              DONE_PORT8,
  input wire logic [ADDR_W-1:0] ADDR_OUT,
  input wire logic [1:0]        BYTE_COUNT_CODE,
  input wire logic [2:0]        FUNCTION_CODE,
  input wire logic              ADDRESS_STROBE_N,
  input wire logic              DATA_STROBE_N,
  input wire logic              READ_WRITE_N
);
  logic [7:0] ack_age_ff;
  logic [7:0] err_age_ff;
  logic [1:0] last_ack_ff;
  logic       ok_ext;
  assign ok_ext = DONE && DONE_RESULT == RESULT_OK && CS_ACK_OPT != ACK_OPT_FAST;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_age_ff  <= 8'hff;
      err_age_ff  <= 8'hff;
      last_ack_ff <= ACK_WAIT;
    end else begin
      ack_age_ff <= (DATA_SIZE_ACK_N != ACK_WAIT) ? 8'h00 : ack_age_ff + {7'h0, ack_age_ff != 8'hff};
      err_age_ff <= !BUS_ERROR_IN_N ? 8'h00 : err_age_ff + {7'h0, err_age_ff != 8'hff};
      if (DATA_SIZE_ACK_N != ACK_WAIT) last_ack_ff <= DATA_SIZE_ACK_N;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  addr_setup_a: assert property ($fell(ADDRESS_STROBE_N) |->
    $stable(ADDR_OUT) && $stable(BYTE_COUNT_CODE)) else $error("address moved with strobe");
  space_hold_a: assert property (!ADDRESS_STROBE_N && $past(!ADDRESS_STROBE_N) |->
    $stable(FUNCTION_CODE) && $stable(ADDR_OUT)) else $error("space code moved in cycle");
  strobe_min_a: assert property ($fell(ADDRESS_STROBE_N) |-> !ADDRESS_STROBE_N[*2])
    else $error("address strobe too short");
  fast_write_a: assert property (!ADDRESS_STROBE_N && !READ_WRITE_N && CS_ACK_OPT == ACK_OPT_FAST
    |-> DATA_STROBE_N) else $error("data strobe in fast write");
  ack_wait_a: assert property (ok_ext |-> ack_age_ff < 8'd16)
    else $error("cycle ended without acknowledge");
  port_width_a: assert property (ok_ext |-> DONE_PORT8 == (last_ack_ff == ACK_PORT8))
    else $error("port width wrong");
  timeout_a: assert property (DONE && DONE_RESULT == RESULT_TIMEOUT |->
    ack_age_ff >= 8'd16 && err_age_ff >= 8'd16) else $error("timeout despite answer");
  bus_error_in_only_a: assert property (DONE && DONE_RESULT == RESULT_BUS_ERR |-> err_age_ff < 8'd16)
    else $error("bus error without input");
  cover property (DONE && DONE_RESULT == RESULT_TIMEOUT);
  cover property (DONE && DONE_RESULT == RESULT_BUS_ERR);
  cover property (!ADDRESS_STROBE_N && !READ_WRITE_N && CS_ACK_OPT == ACK_OPT_FAST);
endmodule // ebc_bm_props

bind ebc_bus_master ebc_bm_props #(.ADDR_W(ADDR_W)) u_props (.CLK(CLK), .RESET_N(RESET_N),
  .CS_ACK_OPT(CS_ACK_OPT), .DATA_SIZE_ACK_N(DATA_SIZE_ACK_N), .BUS_ERROR_IN_N(BUS_ERROR_IN_N),
  .DONE(DONE), .DONE_RESULT(DONE_RESULT), .DONE_PORT8(DONE_PORT8), .ADDR_OUT(ADDR_OUT),
  .BYTE_COUNT_CODE(BYTE_COUNT_CODE), .FUNCTION_CODE(FUNCTION_CODE), .ADDRESS_STROBE_N(ADDRESS_STROBE_N),
  .DATA_STROBE_N(DATA_STROBE_N), .READ_WRITE_N(READ_WRITE_N));

// File: ebc_far_model.sv
// Purpose: Memory or peripheral on the far side of the bus
// Assumes: Terminations have pull-ups, so released lines read high
// Notes:   Data lines toggle during writes, and the low byte during 8-bit reads, so stale data is never mistaken for valid
module ebc_far_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        as_n,
  input  wire logic        rw_n,
  input  wire logic [23:0] addr,
  input  wire logic [3:0]  dly,
  input  wire logic        p8,
  input  wire logic        err,
  input  wire logic        mute,
  output logic      [1:0]  ack_n,
  output logic             bus_error_in_n,
  output logic             halt_n,
  output logic      [15:0] din
);
  logic [7:0]  cnt_ff;
  logic [15:0] pat;
  assign pat = addr[15:0] ^ 16'ha5c3;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 8'h00;
      {ack_n, bus_error_in_n, halt_n} <= 4'hf;
      din <= 16'h5a5a;
    end else begin
      // Hold the answer until the strobe negates
      cnt_ff <= as_n ? 8'h00 : cnt_ff + 8'h01;
      if (as_n) {ack_n, bus_error_in_n, halt_n} <= 4'hf;
      else if (!mute && cnt_ff == {4'h0, dly}) begin
        if (err) {bus_error_in_n, halt_n} <= 2'h0;
        else ack_n <= p8 ? 2'h2 : 2'h1;
      end
      // Fast device: read data follows the address one clock later, as the strobe falls
      din <= rw_n ? (p8 ? {pat[15:8], ~din[7:0]} : pat) : ~din;
    end
  end
endmodule // ebc_far_model

// File: tb_external_bus_cycle_control.sv
// Purpose: Self-checking bench for the bus master
// Assumes: Far side model answers after a chosen delay
// Notes:   Random cycles plus control space, fast, error and timeout cases
module tb_external_bus_cycle_control;
  timeunit 1ns;
  timeprecision 1ns;
  import ebc_pkg::*;
  logic        clk = 0, reset_n = 0, req_valid = 0, req_write = 0, p8 = 0, err = 0, mute = 0;
  logic [1:0]  req_size = 0, mon_sel = 2'h3, result, ack_n, bcc, w_sz;
  logic [23:0] req_addr = 0, addr_out, w_addr;
  logic [2:0]  req_space = 0, fc, w_fc;
  logic [3:0]  req_ctype = 0, ack_opt = ACK_OPT_EXTERNAL, dly = 0;
  logic [15:0] req_wdata = 0, din, rdata, dout, w_do;
  logic        req_ready, done, port8, as_n, ds_n, rw_n, bus_error_in_n, halt_n, w_rw;
  logic [3:0]  ctypes[3] = '{CTYPE_BKPT_ACK, CTYPE_LP_STOP, CTYPE_INT_ACK};
  int          fails = 0, num_checks = 0;
  always #50 clk = ~clk;
  ebc_bus_master DUT (.CLK(clk), .RESET_N(reset_n), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
    .REQ_SIZE(req_size), .REQ_ADDR(req_addr), .REQ_SPACE(req_space), .REQ_CTYPE(req_ctype),
    .REQ_WDATA(req_wdata), .CS_ACK_OPT(ack_opt), .CS_TIMING_SELECT(CS_TIMING_SELECT_ADDR), .MONITOR_PERIOD_SEL(mon_sel),
    .DATA_SIZE_ACK_N(ack_n), .BUS_ERROR_IN_N(bus_error_in_n), .HALT_N(halt_n), .DATA_IN(din), .REQ_READY(req_ready),
    .DONE(done), .DONE_RESULT(result), .DONE_PORT8(port8), .RDATA(rdata), .BUS_REFERENCE_CLOCK(),
    .ADDR_OUT(addr_out), .BYTE_COUNT_CODE(bcc), .FUNCTION_CODE(fc), .ADDRESS_STROBE_N(as_n),
    .DATA_STROBE_N(ds_n), .READ_WRITE_N(rw_n), .DATA_OUT(dout), .DATA_OE());
  ebc_far_model FAR (.clk(clk), .reset_n(reset_n), .as_n(as_n), .rw_n(rw_n), .addr(addr_out), .dly(dly),
    .p8(p8), .err(err), .mute(mute), .ack_n(ack_n), .bus_error_in_n(bus_error_in_n), .halt_n(halt_n), .din(din));
  // Pin values as the address strobe falls
  always @(negedge as_n) {w_addr, w_sz, w_fc, w_rw, w_do} = {addr_out, bcc, fc, rw_n, dout};
  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(logic w, logic [1:0] sz, logic [2:0] sp, logic [3:0] ct, opt, d, logic p, e, m);
    int n;
    logic fast, ok;
    logic [15:0] pat;
    fast = (opt == ACK_OPT_FAST);
    ok = !e && (fast || !m);
    @(negedge clk);
    {req_write, req_size, req_space, req_ctype, ack_opt} = {w, sz, sp, ct, opt};
    {dly, p8, err, mute, req_valid} = {d, p, e, m, 1'b1};
    req_addr = $urandom & 24'hfffffe;
    req_wdata = $urandom;
    pat = req_addr[15:0] ^ 16'ha5c3;
    n = 0;
    while (req_ready !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 0;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    check("done", done, 1'b1);
    check("result", result, (m && !fast) ? RESULT_TIMEOUT : e ? RESULT_BUS_ERR : RESULT_OK);
    check("size", w_sz, sz);
    check("rw", w_rw, !w);
    check("space", w_fc, sp);
    check("addr", sp == FC_CONTROL_SPACE ? w_addr[19:16] : w_addr, sp == FC_CONTROL_SPACE ? ct : req_addr);
    if (w) check("wdata", w_do, sz == SIZE_BYTE ? {2{req_wdata[7:0]}} : req_wdata);
    else if (ok) check("rdata", p ? rdata[7:0] : rdata, p ? pat[15:8] : pat);
    if (ok && !fast) check("port8", port8, p);
    if (m && !fast) begin
      check("tmin", n >= (16 << mon_sel), 1'b1);
      check("tmax", n <= (16 << mon_sel) + 24, 1'b1);
    end else check("span", n >= (fast ? 3 : 5 + d), 1'b1);
  endtask
  initial begin
    logic [3:0] o;
    void'($urandom(32'hcd2673eb));
    repeat (2) @(negedge clk);
    reset_n = 1;
    for (int i = 0; i < 16; i++) begin
      o = $urandom;
      if (o == ACK_OPT_FAST) o = ACK_OPT_EXTERNAL;
      cyc($urandom_range(0, 1), $urandom_range(0, 2), $urandom_range(0, 6), 4'h0, o, $urandom_range(0, 5),
          $urandom_range(0, 1), 1'b0, 1'b0);
    end
    foreach (ctypes[i]) cyc(i == 1, SIZE_WORD, FC_CONTROL_SPACE, ctypes[i], ACK_OPT_EXTERNAL, 0, 0, 0, 0);
    cyc(1, SIZE_BYTE, 3'h2, 4'h0, ACK_OPT_EXTERNAL, 15, 1, 0, 0);
    for (int k = 0; k < 2; k++) begin
      cyc(k, SIZE_WORD, 3'h5, 4'h0, ACK_OPT_FAST, 0, 0, 0, 1);
      cyc(k, SIZE_LONG, 3'h1, 4'h0, ACK_OPT_EXTERNAL, 2, 0, 1, 0);
    end
    for (int s = 0; s < 4; s++) begin
      mon_sel = s;
      cyc(0, SIZE_BYTE, 3'h2, 4'h0, ACK_OPT_EXTERNAL, 0, 0, 0, 1);
    end
    tally_and_finish;
  end
  initial begin
    #500_000;
    fails++;
    tally_and_finish;
  end
endmodule // tb_external_bus_cycle_control
